// *** mtp_defines.vh ***
// Constants for the modulator test pattern control block
`ifndef MTP_DEFINES_VH
`define MTP_DEFINES_VH
// Bus geometry
`define MTP_ADDR_W 18
`define MTP_DATA_W 32
// Register indices; byte address is four times the index
`define MTP_IDX_TEST 18'h0FF4D
`define MTP_IDX_CTRL 18'h0FF40
`define MTP_IDX_MUX 18'h0FF41
`define MTP_IDX_STAT 18'h0FF42
// Test register fields
`define MTP_TEST_EN_BIT 2
`define MTP_PAT_LSB 0
`define MTP_PAT_MSB 1
// Control and mux fields
`define MTP_MOD_EN_BIT 5
`define MTP_MUX_LSB 5
`define MTP_MUX_MSB 6
`define MTP_MUX_EXT 2'h3
// Pattern codes
`define MTP_PAT_MIN 2'h0
`define MTP_PAT_EXT 2'h1
`define MTP_PAT_ALT 2'h2
`define MTP_PAT_MAX 2'h3
// Reset values
`define MTP_TEST_RST 8'h00
`define MTP_CTRL_RST 8'h00
`define MTP_MUX_RST 8'h00
// Status bits
`define MTP_ST_EMPTY 0
`define MTP_ST_FULL 1
`define MTP_ST_OVF 2
`define MTP_ST_ACTIVE 3
// AXI responses
`define MTP_RESP_OKAY 2'h0
`define MTP_RESP_SLVERR 2'h2
// Timing
`define MTP_CLK_HZ 125000000
`define MTP_BIT_CLK_HZ 72000
`define MTP_HALF_W 10
// FIFO shape
`define MTP_FIFO_W 1
`define MTP_FIFO_D 8
`define MTP_FIFO_AW 3
`endif

// *** mtp_top.v ***
// Modulator test pattern control with AXI4-Lite registers and external bit FIFO
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "mtp_defines.vh"

// What this block does
// - Test mode replaces formatter data with test source
// - Bit 2 enables constant transmission test mode
// - Pattern field picks min, external, alternating, max
// - Output 72 kHz clock, sample data rising
// - Nothing transmitted unless modulator enable bit set

//--------------------------------------------------
// Bit FIFO
//--------------------------------------------------
module mtp_fifo #(
   parameter W = 1,
   parameter D = 8,
   parameter AW = 3
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Fill side
   input wire in_valid,
   input wire [W-1:0] in_data,
   output wire in_ready,
   // Drain side
   output wire out_valid,
   output wire [W-1:0] out_data,
   input wire out_ready
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wp_reg;
   reg [AW-1:0] rp_reg;
   reg [AW:0] cnt_reg;
   wire push;
   wire pop;
   assign in_ready = (cnt_reg != D[AW:0]);
   assign out_valid = (cnt_reg != {(AW+1){1'b0}});
   assign out_data = mem[rp_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   // Storage write
   always @(posedge aclk) begin
      if (push) begin
         mem[wp_reg] <= in_data;
      end
   end
   // Pointers and fill count
   always @(posedge aclk) begin
      if (!aresetn) begin
         wp_reg <= {AW{1'b0}};
         rp_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_reg <= (wp_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= (rp_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_reg + 1'b1;
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule

//--------------------------------------------------
// Top
//--------------------------------------------------
module mtp_top (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire s_axi_awvalid,
   input wire [`MTP_ADDR_W-1:0] s_axi_awaddr,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire s_axi_wvalid,
   input wire [`MTP_DATA_W-1:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg s_axi_bvalid,
   output reg [1:0] s_axi_bresp,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire s_axi_arvalid,
   input wire [`MTP_ADDR_W-1:0] s_axi_araddr,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg s_axi_rvalid,
   output reg [`MTP_DATA_W-1:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   input wire s_axi_rready,
   // Formatter data in
   input wire fmt_bit,
   // Modulator drive
   output reg mod_tx_bit,
   output reg mod_tx_active,
   output reg mod_bit_strobe,
   // Test pins
   output reg test_bit_clock_pin,
   output reg test_bit_clock_pin_oe,
   input wire external_test_data_pin
);
   // Half period in clock cycles, rounded down, cut to the counter width
   localparam integer HALF_INT = `MTP_CLK_HZ / (2 * `MTP_BIT_CLK_HZ);
   localparam [`MTP_HALF_W-1:0] HALF_CYC = HALF_INT[`MTP_HALF_W-1:0];

   // Mapped check
   function mtp_hit;
      input [`MTP_ADDR_W-1:0] a;
      input [`MTP_ADDR_W-1:0] idx;
      begin
         mtp_hit = (a == {idx[`MTP_ADDR_W-3:0], 2'b00});
      end
   endfunction

   reg [7:0] modulator_test_mode_reg;
   reg [7:0] modulator_control_register_reg;
   reg [7:0] baseband_pin_mux_reg;
   reg ovf_reg;
   reg aw_got_reg;
   reg w_got_reg;
   reg [`MTP_ADDR_W-1:0] aw_addr_reg;
   reg [`MTP_DATA_W-1:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg [`MTP_HALF_W-1:0] half_cnt_reg;
   reg [2:0] sync_reg;
   reg alt_reg;
   reg smp_valid_reg;
   reg smp_bit_reg;
   wire rise_en;
   wire mod_en;
   wire test_en;
   wire [1:0] pattern;
   wire mux_ext;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_out_data;
   wire fifo_pop;
   wire wr_go;
   wire [`MTP_ADDR_W-1:0] wa;
   reg tx_next;

   assign mod_en = modulator_control_register_reg[`MTP_MOD_EN_BIT];
   assign test_en = modulator_test_mode_reg[`MTP_TEST_EN_BIT];
   assign pattern = modulator_test_mode_reg[`MTP_PAT_MSB:`MTP_PAT_LSB];
   assign mux_ext = (baseband_pin_mux_reg[`MTP_MUX_MSB:`MTP_MUX_LSB] == `MTP_MUX_EXT);
   assign wr_go = aw_got_reg && w_got_reg && !s_axi_bvalid;
   assign wa = aw_addr_reg;

   //--------------------------------------------------
   // AXI4-Lite write channel
   //--------------------------------------------------
   // Address and data taken in either order, answered once both held
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MTP_RESP_OKAY;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         aw_addr_reg <= {`MTP_ADDR_W{1'b0}};
         w_data_reg <= {`MTP_DATA_W{1'b0}};
         w_strb_reg <= 4'h0;
      end else begin
         s_axi_awready <= !aw_got_reg && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_got_reg && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (mtp_hit(wa, `MTP_IDX_TEST) || mtp_hit(wa, `MTP_IDX_CTRL) ||
                            mtp_hit(wa, `MTP_IDX_MUX) || mtp_hit(wa, `MTP_IDX_STAT)) ?
                           `MTP_RESP_OKAY : `MTP_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   //--------------------------------------------------
   // Registers
   //--------------------------------------------------
   // Register writes; overflow flag set wins over clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         modulator_test_mode_reg <= `MTP_TEST_RST;
         modulator_control_register_reg <= `MTP_CTRL_RST;
         baseband_pin_mux_reg <= `MTP_MUX_RST;
         ovf_reg <= 1'b0;
      end else begin
         if (wr_go && w_strb_reg[0]) begin
            if (mtp_hit(wa, `MTP_IDX_TEST)) begin
               modulator_test_mode_reg <= {5'h00, w_data_reg[`MTP_TEST_EN_BIT:0]};
            end
            if (mtp_hit(wa, `MTP_IDX_CTRL)) begin
               modulator_control_register_reg <= w_data_reg[7:0];
            end
            if (mtp_hit(wa, `MTP_IDX_MUX)) begin
               baseband_pin_mux_reg <= w_data_reg[7:0];
            end
            if (mtp_hit(wa, `MTP_IDX_STAT) && w_data_reg[`MTP_ST_OVF]) begin
               ovf_reg <= 1'b0;
            end
         end
         if (smp_valid_reg && !fifo_in_ready) begin
            ovf_reg <= 1'b1;
         end
      end
   end

   //--------------------------------------------------
   // AXI4-Lite read channel
   //--------------------------------------------------
   // One read at a time, answered the cycle after acceptance
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= {`MTP_DATA_W{1'b0}};
         s_axi_rresp <= `MTP_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `MTP_RESP_OKAY;
            s_axi_rdata <= {`MTP_DATA_W{1'b0}};
            if (mtp_hit(s_axi_araddr, `MTP_IDX_TEST)) begin
               s_axi_rdata[7:0] <= modulator_test_mode_reg;
            end else if (mtp_hit(s_axi_araddr, `MTP_IDX_CTRL)) begin
               s_axi_rdata[7:0] <= modulator_control_register_reg;
            end else if (mtp_hit(s_axi_araddr, `MTP_IDX_MUX)) begin
               s_axi_rdata[7:0] <= baseband_pin_mux_reg;
            end else if (mtp_hit(s_axi_araddr, `MTP_IDX_STAT)) begin
               s_axi_rdata[`MTP_ST_EMPTY] <= !fifo_out_valid;
               s_axi_rdata[`MTP_ST_FULL] <= !fifo_in_ready;
               s_axi_rdata[`MTP_ST_OVF] <= ovf_reg;
               s_axi_rdata[`MTP_ST_ACTIVE] <= mod_tx_active;
            end else begin
               s_axi_rresp <= `MTP_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   //--------------------------------------------------
   // Test bit clock and data sampling
   //--------------------------------------------------
   assign rise_en = (half_cnt_reg == HALF_CYC - 1'b1) && !test_bit_clock_pin;

   // divider makes the 72 kHz pin clock
   always @(posedge aclk) begin
      if (!aresetn) begin
         half_cnt_reg <= {`MTP_HALF_W{1'b0}};
         test_bit_clock_pin <= 1'b0;
         test_bit_clock_pin_oe <= 1'b0;
      end else begin
         test_bit_clock_pin_oe <= mux_ext;
         if (half_cnt_reg == HALF_CYC - 1'b1) begin
            half_cnt_reg <= {`MTP_HALF_W{1'b0}};
            test_bit_clock_pin <= !test_bit_clock_pin;
         end else begin
            half_cnt_reg <= half_cnt_reg + 1'b1;
         end
      end
   end

   // Three-stage synchroniser on the data pin
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_sync
         always @(posedge aclk) begin
            if (!aresetn) begin
               sync_reg[g] <= 1'b0;
            end else begin
               sync_reg[g] <= (g == 0) ? external_test_data_pin : sync_reg[(g == 0) ? 0 : g - 1];
            end
         end
      end
   endgenerate

   // pins only carry test data with mux at 11
   // capture data at each rising clock edge in external pattern mode with modulator enabled, where the last two synchroniser stages agree
   always @(posedge aclk) begin
      if (!aresetn) begin
         smp_valid_reg <= 1'b0;
         smp_bit_reg <= 1'b0;
      end else begin
         smp_valid_reg <= rise_en && mux_ext && test_en && (pattern == `MTP_PAT_EXT) && mod_en &&
                          (sync_reg[1] == sync_reg[2]);
         if (sync_reg[1] == sync_reg[2]) begin
            smp_bit_reg <= sync_reg[2];
         end
      end
   end

   mtp_fifo #(
      .W(`MTP_FIFO_W),
      .D(`MTP_FIFO_D),
      .AW(`MTP_FIFO_AW)
   ) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(smp_valid_reg),
      .in_data(smp_bit_reg),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(fifo_pop)
   );

   //--------------------------------------------------
   // Modulator data selection
   //--------------------------------------------------
   assign fifo_pop = rise_en && mod_en && test_en && (pattern == `MTP_PAT_EXT);

   always @* begin
      tx_next = fmt_bit;
      if (test_en) begin
         case (pattern)
            `MTP_PAT_MIN: tx_next = 1'b0;
            `MTP_PAT_EXT: tx_next = fifo_out_valid ? fifo_out_data : mod_tx_bit;
            `MTP_PAT_ALT: tx_next = alt_reg;
            `MTP_PAT_MAX: tx_next = 1'b1;
            default: tx_next = 1'b0;
         endcase
      end
   end

   // output held idle while modulator disabled
   always @(posedge aclk) begin
      if (!aresetn) begin
         mod_tx_bit <= 1'b0;
         mod_tx_active <= 1'b0;
         mod_bit_strobe <= 1'b0;
         alt_reg <= 1'b0;
      end else begin
         mod_tx_active <= mod_en;
         mod_bit_strobe <= rise_en && mod_en;
         if (!mod_en) begin
            mod_tx_bit <= 1'b0;
            alt_reg <= 1'b0;
         end else if (rise_en) begin
            mod_tx_bit <= tx_next;
            alt_reg <= !alt_reg;
         end
      end
   end
endmodule

// *** mtp_properties.sv ***
// Port checker for the modulator test pattern control block
`timescale 1ns/1ns
module mtp_props (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Register bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire [31:0] s_axi_rdata,
   // Modulator and link
   input wire mod_tx_bit,
   input wire mod_tx_active,
   input wire mod_bit_strobe,
   input wire test_bit_clock_pin
);
   logic [15:0] hcnt;
   logic [15:0] scnt;
   logic pin_d;
   logic hseen;
   logic sseen;
   wire tog = test_bit_clock_pin != pin_d;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   //----------------------------
   // Interval counters
   //----------------------------
   // Cycles since last pin toggle and last strobe
   always @(posedge aclk) begin
      if (!aresetn) begin
         hcnt <= 16'h0;
         scnt <= 16'h0;
         pin_d <= 1'b0;
         hseen <= 1'b0;
         sseen <= 1'b0;
      end else begin
         pin_d <= test_bit_clock_pin;
         hcnt <= tog ? 16'h0 : hcnt + 16'h1;
         hseen <= hseen | tog;
         scnt <= mod_bit_strobe ? 16'h0 : scnt + 16'h1;
         sseen <= mod_tx_active & (sseen | mod_bit_strobe);
      end
   end
   //----------------------------
   // Properties
   //----------------------------
   sequence s_wtake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rtake;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_wresp; s_wtake |-> ##2 s_axi_bvalid; endproperty
   a_wresp: assert property (p_wresp) else $error("Write response late");
   property p_wblk; s_wtake |=> !s_axi_awready && !s_axi_wready; endproperty
   a_wblk: assert property (p_wblk) else $error("Write taken twice");
   property p_rresp; s_rtake |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0; endproperty
   a_rresp: assert property (p_rresp) else $error("Read response wrong");
   property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arblk: assert property (p_arblk) else $error("Read accepted while busy");
   property p_rst; $rose(aresetn) |=> s_axi_awready && s_axi_wready && s_axi_arready; endproperty
   a_rst: assert property (p_rst) else $error("Bus not ready after reset");
   property p_half; tog && hseen |-> hcnt == 16'h0363; endproperty
   a_half: assert property (p_half) else $error("Bit clock half period wrong");
   property p_per; mod_bit_strobe && sseen |-> scnt == 16'h06C7; endproperty
   a_per: assert property (p_per) else $error("Bit period wrong");
   property p_off; !mod_tx_active && !$past(mod_tx_active) |-> !mod_bit_strobe && !mod_tx_bit; endproperty
   a_off: assert property (p_off) else $error("Output while disabled");
   property p_bitch; mod_tx_active && $changed(mod_tx_bit) |-> mod_bit_strobe; endproperty
   a_bitch: assert property (p_bitch) else $error("Bit changed off strobe");
endmodule
bind mtp_top mtp_props mtp_props_i (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
   .mod_tx_bit(mod_tx_bit), .mod_tx_active(mod_tx_active), .mod_bit_strobe(mod_bit_strobe),
   .test_bit_clock_pin(test_bit_clock_pin));

// *** mtp_ext_src.sv ***
// External test data source on aclk, stepping at each falling edge of the device bit clock
`timescale 1ns/1ns
module mtp_ext_src (
   // Clock
   input wire aclk,
   // Link
   input wire test_bit_clock_pin,
   output reg external_test_data_pin,
   // Bits to send, lowest first
   input wire [7:0] pattern
);
   reg pin_d = 1'b0;
   reg [2:0] idx = 3'h0;
   initial external_test_data_pin = 1'b0;
   always @(posedge aclk) begin
      pin_d <= test_bit_clock_pin;
      if (pin_d && !test_bit_clock_pin) begin
         external_test_data_pin <= pattern[idx];
         idx <= idx + 3'h1;
      end
   end
endmodule

// *** testbench.sv ***
// Testbench for the modulator test pattern control block
`timescale 1ns/1ns
`include "mtp_defines.vh"
module testbench;
   localparam [17:0] A_TEST = `MTP_IDX_TEST << 2;
   localparam [17:0] A_CTRL = `MTP_IDX_CTRL << 2;
   localparam [17:0] A_MUX = `MTP_IDX_MUX << 2;
   localparam [17:0] A_STAT = `MTP_IDX_STAT << 2;
   localparam [7:0] ST_IDLE = 8'h01 << `MTP_ST_EMPTY;
   localparam [7:0] ST_ON = ST_IDLE | (8'h01 << `MTP_ST_ACTIVE);
   localparam [7:0] EXT_PAT = 8'hB4;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg awvalid = 1'b0;
   reg wvalid = 1'b0;
   reg arvalid = 1'b0;
   reg fmt_bit = 1'b0;
   reg [17:0] awaddr = 18'h0;
   reg [17:0] araddr = 18'h0;
   reg [31:0] wdata = 32'h0;
   wire awready, wready, bvalid, arready, rvalid, mod_tx_bit, mod_tx_active, strobe, pin, oe, ext;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   integer failures = 0;
   integer checks_done = 0;
   integer cycles = 0;
   mtp_top mtp_top_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(awvalid), .s_axi_awaddr(awaddr), .s_axi_awready(awready),
      .s_axi_wvalid(wvalid), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wready(wready),
      .s_axi_bvalid(bvalid), .s_axi_bresp(bresp), .s_axi_bready(1'b1),
      .s_axi_arvalid(arvalid), .s_axi_araddr(araddr), .s_axi_arready(arready),
      .s_axi_rvalid(rvalid), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rready(1'b1),
      .fmt_bit(fmt_bit), .mod_tx_bit(mod_tx_bit), .mod_tx_active(mod_tx_active),
      .mod_bit_strobe(strobe), .test_bit_clock_pin(pin), .test_bit_clock_pin_oe(oe),
      .external_test_data_pin(ext));
   mtp_ext_src mtp_ext_src_i (.aclk(aclk), .test_bit_clock_pin(pin),
      .external_test_data_pin(ext), .pattern(EXT_PAT));
   // Clock
   initial begin
      forever #4 aclk = ~aclk;
   end
   // Compare and count
   task check(input [31:0] seen, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task close_out;
      begin
         $display("Checks %0d, mismatches %0d", checks_done, failures);
         if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // Hang guard
   always @(posedge aclk) begin
      cycles = cycles + 1;
      if (cycles == 80000) begin
         failures = failures + 1;
         close_out;
      end
   end
   // Register write, response always accepted
   task wr(input [17:0] a, input [7:0] d, input [1:0] er);
      reg done;
      begin
         awaddr <= a;
         wdata <= {24'h0, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         done = 1'b0;
         while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
               done = 1'b1;
               check(bresp, er);
            end
         end
      end
   endtask
   // Register read
   task rd(input [17:0] a, input [7:0] ex, input [1:0] er);
      reg done;
      begin
         araddr <= a;
         arvalid <= 1'b1;
         done = 1'b0;
         while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
               done = 1'b1;
               check(rdata, {24'h0, ex});
               check(rresp, er);
            end
         end
      end
   endtask
   // Collect bits sent at each strobe
   task bits(input integer n, output [15:0] got);
      integer i;
      integer k;
      begin
         got = 16'h0;
         for (i = 0; i < n; i = i + 1) begin
            k = 0;
            while (strobe !== 1'b1 && k < 2000) begin
               @(posedge aclk);
               k = k + 1;
            end
            check(strobe, 1'b1);
            got[i] = mod_tx_bit;
            @(posedge aclk);
         end
      end
   endtask
   task t_reset;
      begin
         check(oe, 1'b0);
         rd(A_TEST, `MTP_TEST_RST, `MTP_RESP_OKAY);
         rd(A_CTRL, `MTP_CTRL_RST, `MTP_RESP_OKAY);
         rd(A_MUX, `MTP_MUX_RST, `MTP_RESP_OKAY);
         rd(A_STAT, ST_IDLE, `MTP_RESP_OKAY);
         rd(18'h00010, 8'h00, `MTP_RESP_SLVERR);
      end
   endtask
   task t_off;
      begin
         fmt_bit <= 1'b1;
         wr(A_TEST, 8'hFF, `MTP_RESP_OKAY);
         rd(A_TEST, 8'h07, `MTP_RESP_OKAY);
         repeat (4 * 868) @(posedge aclk);
         check(mod_tx_active, 1'b0);
         check(mod_tx_bit, 1'b0);
      end
   endtask
   // One pattern code, formatter held opposite for the fixed codes, at the expected level with test mode off
   task t_code(input [7:0] val, input f, input [2:0] exp_bits);
      reg [15:0] got;
      reg [2:0] ex;
      begin
         fmt_bit <= f;
         wr(A_TEST, val, `MTP_RESP_OKAY);
         bits(4, got);
         ex = exp_bits;
         if (val[1:0] == `MTP_PAT_ALT) ex = {~got[2], got[2], ~got[2]};
         check(got[3:1], ex);
      end
   endtask
   task t_codes;
      begin
         wr(A_CTRL, 8'h20, `MTP_RESP_OKAY);
         t_code(8'h04, 1'b1, 3'h0);
         t_code(8'h07, 1'b0, 3'h7);
         t_code(8'h06, 1'b0, 3'h0);
         t_code(8'h00, 1'b1, 3'h7);
         check(mod_tx_active, 1'b1);
         rd(A_STAT, ST_ON, `MTP_RESP_OKAY);
      end
   endtask
   task t_ext;
      reg [15:0] got;
      reg [15:0] rot;
      reg hit;
      integer r;
      begin
         wr(A_MUX, 8'h60, `MTP_RESP_OKAY);
         wr(A_TEST, 8'h05, `MTP_RESP_OKAY);
         check(oe, 1'b1);
         bits(14, got);
         hit = 1'b0;
         for (r = 0; r < 8; r = r + 1) begin
            rot = {EXT_PAT, EXT_PAT} >> r;
            if (got[13:6] === rot[7:0]) hit = 1'b1;
         end
         check(hit, 1'b1);
      end
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      t_reset;
      t_off;
      t_codes;
      t_ext;
      close_out;
   end
endmodule
